// [can_rxdbg_consts.svh]
// constants for the receive fifo top pointer and debug message block
// What this block does
// [RL1] hardware computes next fifo read address
// [RL2] read address wraps after fifo size reads
// [RL3] one element fifo must also wrap correctly
// [RL4] software should use size two or more
// [RL5] one element fifo: software reads ram directly
// [RL6] init hold or bus off keeps debug state
// [RL7] config change enable leaves debug state unchanged
// [RL8] debug off keeps state machine idle
// [RL9] state visible; state three holds dma request
// [RL10] states one, two leave on debug reception
// [RL11] reset gives idle state, dma request low
`ifndef CAN_RXDBG_CONSTS_SVH
`define CAN_RXDBG_CONSTS_SVH
`define OFS_CORE_CTRL    12'h000
`define OFS_FIFO0_CFG    12'h004
`define OFS_FIFO1_CFG    12'h008
`define OFS_FIFO0_TOP    12'h00c
`define OFS_FIFO1_TOP    12'h010
`define OFS_FIFO1_STAT   12'h014
`define OFS_IRQ_STAT     12'h018
`define OFS_IRQ_MASK     12'h01c
`define OFS_FIFO0_STAT   12'h020
// core control fields
`define BIT_INIT         0
`define BIT_CFG_CHG      1
`define BIT_DBG_EN       2
`define BIT_BUS_OFF      3
// fifo config fields: start word address [15:2], size [22:16]
`define CFG_SA_LSB       2
`define CFG_SA_MSB       15
`define CFG_SZ_LSB       16
`define CFG_SZ_MSB       22
// fifo status fields: fill [6:0], get index [13:8], debug state [31:30] in fifo 1 status only
`define ST_GI_LSB        8
`define ST_DBG_LSB       30
// element stride in message ram words
`define ELEM_WORDS       16'h0048
`define RST_CTRL         32'h0000_0001
`define RST_ZERO         32'h0000_0000
`endif

// [can_rxdbg_pkg.sv]
// types shared by the receive fifo and debug message block
package can_rxdbg_pkg;
    typedef enum logic [1:0] {
        DBG_IDLE = 2'b00,   // no debug message pending
        DBG_ONE  = 2'b01,   // first debug message taken
        DBG_TWO  = 2'b10,   // second debug message taken
        DBG_DMA  = 2'b11    // third taken, dma request raised
    } dbg_state_t;
    typedef logic [15:0] addr_t;
endpackage

// [can_rx_fifo_debug_msg.sv]
// receive fifo top pointers, debug message state machine and apb registers
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "can_rxdbg_consts.svh"
module can_rx_fifo_debug_msg
    import can_rxdbg_pkg::*;
(
    input  wire logic        mclk,       // system clock, 10 MHz
    input  wire logic        nrst,       // async reset, active low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb write
    input  wire logic [11:0] paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic      [31:0] prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error, unmapped address
    input  wire logic        rxStore0,   // pulse: message stored into fifo 0
    input  wire logic        rxStore1,   // pulse: message stored into fifo 1
    input  wire logic        topRead0,   // pulse: reader fetched fifo 0 top element
    input  wire logic        topRead1,   // pulse: reader fetched fifo 1 top element
    input  wire logic        debugMsgRx, // pulse: debug message received
    input  wire logic        busOffIn,   // level: protocol engine is bus off
    output logic      [15:0] topAddr0,   // message ram word address of fifo 0 top
    output logic      [15:0] topAddr1,   // message ram word address of fifo 1 top
    output logic             dmaReq,     // debug message dma request
    output logic             irq         // level interrupt
);
    // apb decode
    wire        acc      = psel && penable;              // access phase
    wire        wrAcc    = acc && pwrite;                // write strobe
    wire        selCtrl  = paddr == `OFS_CORE_CTRL;
    wire        selCfg0  = paddr == `OFS_FIFO0_CFG;
    wire        selCfg1  = paddr == `OFS_FIFO1_CFG;
    wire        selTop0  = paddr == `OFS_FIFO0_TOP;
    wire        selTop1  = paddr == `OFS_FIFO1_TOP;
    wire        selSt1   = paddr == `OFS_FIFO1_STAT;
    wire        selSt0   = paddr == `OFS_FIFO0_STAT;
    wire        selIst   = paddr == `OFS_IRQ_STAT;
    wire        selImk   = paddr == `OFS_IRQ_MASK;
    wire        mapped   = selCtrl | selCfg0 | selCfg1 | selTop0 | selTop1
                         | selSt1 | selSt0 | selIst | selImk;

    logic [31:0] ctrl_reg;       // core control register
    logic [31:0] cfg0_reg;       // fifo 0 config
    logic [31:0] cfg1_reg;       // fifo 1 config
    logic [6:0]  fill0_reg;      // fifo 0 fill level
    logic [6:0]  fill1_reg;      // fifo 1 fill level
    logic [5:0]  get0_reg;       // fifo 0 get index
    logic [5:0]  get1_reg;       // fifo 1 get index
    dbg_state_t  dbgState_reg;   // debug message state
    logic [3:0]  ist_reg;        // sticky events
    logic [3:0]  imk_reg;        // interrupt mask

    // control fields
    wire initHold = ctrl_reg[`BIT_INIT];
    wire dbgEn    = ctrl_reg[`BIT_DBG_EN];
    wire [6:0] size0 = cfg0_reg[`CFG_SZ_MSB:`CFG_SZ_LSB];
    wire [6:0] size1 = cfg1_reg[`CFG_SZ_MSB:`CFG_SZ_LSB];

    // next get index, wrapping at fifo size (size one wraps to zero too)
    function automatic logic [5:0] nextGet(input logic [5:0] g, input logic [6:0] sz);
        logic [6:0] n;
        n = {1'b0, g} + 7'h01;
        nextGet = (n >= sz) ? 6'h00 : n[5:0];  // [RL2] [RL3]
    endfunction

    // top address = start + index * element stride
    function automatic addr_t topOf(input logic [31:0] cfg, input logic [5:0] g);
        logic [21:0] p;
        p = {16'h0000, g} * {6'h00, `ELEM_WORDS};
        topOf = addr_t'(cfg[`CFG_SA_MSB:`CFG_SA_LSB]) + p[15:0];  // [RL1]
    endfunction

    // fill level bookkeeping
    function automatic logic [6:0] nextFill(input logic [6:0] f, input logic [6:0] sz,
                                            input logic st, input logic rd);
        logic up;
        logic dn;
        up = st && (f < sz);
        dn = rd && (f != 7'h00);
        nextFill = f + {6'h00, up} - {6'h00, dn};
    endfunction

    wire pop0 = topRead0 && fill0_reg != 7'h00;
    wire pop1 = topRead1 && fill1_reg != 7'h00;
    wire ovf0 = rxStore0 && fill0_reg >= size0;
    wire ovf1 = rxStore1 && fill1_reg >= size1;

    // debug message state: advances only with debug enabled; init hold,
    // bus off and config change enable do not force it back to idle
    dbg_state_t dbgState_next;
    always_comb begin
        dbgState_next = dbgState_reg;                          // [RL6] [RL7]
        if (!dbgEn) begin
            dbgState_next = DBG_IDLE;                          // [RL8]
        end else if (debugMsgRx && !initHold && !busOffIn) begin
            // a state stopped in one or two moves on again once init is clear
            case (dbgState_reg)
                DBG_IDLE: dbgState_next = DBG_ONE;
                DBG_ONE:  dbgState_next = DBG_TWO;             // [RL10]
                DBG_TWO:  dbgState_next = DBG_DMA;             // [RL10]
                DBG_DMA:  dbgState_next = DBG_DMA;             // [RL9]
                default:  dbgState_next = DBG_IDLE;
            endcase
        end
    end
    wire dmaNext = dbgState_next == DBG_DMA;                   // [RL9]

    // events: fifo 0 store, fifo 1 store, overflow, dma request rise
    wire [3:0] evt = {dmaNext && !dmaReq, ovf0 | ovf1, rxStore1, rxStore0};
    wire [3:0] istClr = (wrAcc && selIst) ? pwdata[3:0] : 4'h0;

    // read mux
    wire [31:0] rdMux =
          selCtrl ? ctrl_reg
        : selCfg0 ? cfg0_reg
        : selCfg1 ? cfg1_reg
        : selTop0 ? {16'h0000, topAddr0}
        : selTop1 ? {16'h0000, topAddr1}
        : selSt0  ? {18'h00000, get0_reg, 1'b0, fill0_reg}
        : selSt1  ? {dbgState_reg, 10'h000, 6'h00, get1_reg, 1'b0, fill1_reg}  // [RL9]
        : selIst  ? {28'h0000000, ist_reg}
        : selImk  ? {28'h0000000, imk_reg}
        : 32'h0000_0000;

    // software registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `RST_CTRL;
            cfg0_reg <= `RST_ZERO;
            cfg1_reg <= `RST_ZERO;
            imk_reg  <= 4'h0;
        end else if (wrAcc) begin
            if (selCtrl) ctrl_reg <= {28'h0000000, busOffIn, pwdata[2:0]};
            if (selCfg0) cfg0_reg <= pwdata;
            if (selCfg1) cfg1_reg <= pwdata;
            if (selImk)  imk_reg  <= pwdata[3:0];
        end else begin
            ctrl_reg[`BIT_BUS_OFF] <= busOffIn;
        end
    end

    // fifo pointers: get index advances per top read of a non-empty fifo
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            get0_reg  <= 6'h00;
            get1_reg  <= 6'h00;
            fill0_reg <= 7'h00;
            fill1_reg <= 7'h00;
        end else begin
            if (pop0) get0_reg <= nextGet(get0_reg, size0);  // [RL2]
            if (pop1) get1_reg <= nextGet(get1_reg, size1);  // [RL2]
            fill0_reg <= nextFill(fill0_reg, size0, rxStore0, topRead0);
            fill1_reg <= nextFill(fill1_reg, size1, rxStore1, topRead1);
        end
    end

    // top addresses registered so outputs come from flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            topAddr0 <= 16'h0000;
            topAddr1 <= 16'h0000;
        end else begin
            topAddr0 <= topOf(cfg0_reg, pop0 ? nextGet(get0_reg, size0) : get0_reg); // [RL1]
            topAddr1 <= topOf(cfg1_reg, pop1 ? nextGet(get1_reg, size1) : get1_reg); // [RL1]
        end
    end

    // debug state machine and dma request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dbgState_reg <= DBG_IDLE;                  // [RL11]
            dmaReq  <= 1'b0;                           // [RL11]
        end else begin
            dbgState_reg <= dbgState_next;             // [RL10]
            dmaReq  <= dmaNext;                        // [RL9]
        end
    end

    // interrupt status, set wins over clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ist_reg <= 4'h0;
            irq     <= 1'b0;
        end else begin
            ist_reg <= (ist_reg & ~istClr) | evt;
            irq     <= |(((ist_reg & ~istClr) | evt) & imk_reg);
        end
    end

    // apb answer: zero wait state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end
endmodule

// [can_node_model.sv]
// far-side can node model: delivers stored and debug frames as pulses
module can_node_model (
    input  wire logic       mclk,       // system clock
    input  wire logic [1:0] kind,       // 1 fifo 0, 2 fifo 1, 3 debug
    input  wire logic       send,       // deliver one frame
    output logic            rxStore0,   // frame stored in fifo 0
    output logic            rxStore1,   // frame stored in fifo 1
    output logic            debugMsgRx  // debug frame taken
);
    timeunit 1ns;
    timeprecision 1ns;
    // one clean pulse per frame, never stretched
    always_ff @(posedge mclk) begin
        rxStore0   <= send && kind == 2'h1;
        rxStore1   <= send && kind == 2'h2;
        debugMsgRx <= send && kind == 2'h3;
    end
endmodule

// [can_rx_fifo_debug_msg_props.sv]
// assertion checker for the fifo pointer and debug message block
module can_rx_fifo_debug_msg_props (
    input wire logic        mclk,       // clock
    input wire logic        nrst,       // reset
    input wire logic        psel,       // apb
    input wire logic        penable,    // apb
    input wire logic        pwrite,     // apb
    input wire logic [31:0] prdata,     // apb
    input wire logic        pready,     // apb
    input wire logic        pslverr,    // apb
    input wire logic        debugMsgRx, // debug frame
    input wire logic        topRead0,   // fifo 0 pop
    input wire logic [15:0] topAddr0,   // fifo 0 top
    input wire logic        dmaReq,     // dma request
    input wire logic        irq         // interrupt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic wrAcc = psel && penable && pwrite; // write access cycle
    // setup phase of an apb transfer
    sequence apbSetup;
        psel && !penable;
    endsequence
    ready_after_setup_a: assert property (apbSetup |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    read_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    dma_hold_a: assert property (dmaReq && !wrAcc && !$past(wrAcc) |=> dmaReq)
        else $error("dma request dropped");
    dma_cause_a: assert property ($rose(dmaReq) |->
        $past(debugMsgRx) || $past(debugMsgRx, 2)) else $error("dma with no frame");
    reset_idle_a: assert property (!$past(nrst) |-> !dmaReq && !irq && !pready)
        else $error("busy after reset");
    top_cause_a: assert property ($changed(topAddr0) |->
        $past(topRead0) || $past(topRead0, 2) || $past(wrAcc) || $past(wrAcc, 2))
        else $error("top moved with no read");
endmodule
bind can_rx_fifo_debug_msg can_rx_fifo_debug_msg_props chk (.*);

// [can_rx_fifo_debug_msg_test.sv]
// self-checking bench for the fifo top pointers and debug message state
module can_rx_fifo_debug_msg_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0; // clock, apb
    logic        send = 0, busOffIn = 0, topRead0 = 0, topRead1 = 0;   // stimulus
    logic [1:0]  kind = 0;                                             // frame kind
    logic [11:0] paddr = 0;                                            // apb address
    logic [31:0] pwdata = 0, prdata;                                   // apb data
    logic [15:0] topAddr0, topAddr1;                                   // top pointers
    logic        pready, pslverr, dmaReq, irq, rxStore0, rxStore1, debugMsgRx;
    logic [63:0] expQ[$];                                              // mask, value
    int          fails = 0, n_compared = 0, sz;
    localparam logic [31:0] stateMask = 32'hc0000000;                  // state field
    can_rx_fifo_debug_msg uut (.*);
    can_node_model node (.*);
    initial forever #50 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one apb transfer, held until ready, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1;
        for (int i = 0; i < 16 && pready !== 1'b1; i++) @(posedge mclk);
        check({31'b0, pready}, 32'h1);
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        expQ.push_back({m, v});
        apb(0, a, 32'h0);
    endtask
    task automatic frame(input logic [1:0] k);
        kind <= k;
        send <= 1;
        @(posedge mclk) send <= 0;
        @(posedge mclk);
    endtask
    task automatic pop(input int n);
        topRead0 <= n == 0;
        topRead1 <= n == 1;
        @(posedge mclk) {topRead0, topRead1} <= 2'b00;
        @(posedge mclk);
    endtask
    // watcher: each answered read is compared with the oldest note
    always @(posedge mclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0) begin
            check(prdata & expQ[0][63:32], expQ[0][31:0]);
            void'(expQ.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h439d));
        repeat (12) @(posedge mclk);
        nrst <= 1;
        @(posedge mclk);
        rd(12'h000, 32'hffffffff, 32'h1);
        rd(12'h014, 32'hffffffff, 32'h0);
        rd(12'h024, 32'hffffffff, 32'h0);
        apb(1, 12'h000, 32'h0);
        // size one on fifo 0, random size on fifo 1, read past the wrap
        for (int n = 0; n < 2; n++) begin
            sz = n ? $urandom_range(8, 2) : 1;
            apb(1, n ? 12'h008 : 12'h004, 32'(sz) << 16);
            repeat (sz) frame(2'(n + 1));
            for (int k = 0; k <= sz; k++) begin
                rd(n ? 12'h010 : 12'h00c, 32'hffff, 32'(k % sz) * 32'h48);
                pop(n);
            end
        end
        repeat (2) frame(2'h3);
        rd(12'h014, stateMask, 32'h0);
        apb(1, 12'h000, 32'h4);
        frame(2'h3);
        rd(12'h014, stateMask, 32'h40000000);
        apb(1, 12'h000, 32'h5);
        frame(2'h3);
        apb(1, 12'h000, 32'h7);
        rd(12'h014, stateMask, 32'h40000000);
        apb(1, 12'h000, 32'h4);
        busOffIn <= 1;
        frame(2'h3);
        rd(12'h014, stateMask, 32'h40000000);
        busOffIn <= 0;
        repeat (2) frame(2'h3);
        rd(12'h014, stateMask, stateMask);
        apb(1, 12'h01c, 32'h8);
        apb(1, 12'h000, 32'h5);
        frame(2'h3);
        check({31'b0, dmaReq}, 32'h1);
        check({31'b0, irq}, 32'h1);
        apb(1, 12'h018, 32'hf);
        @(posedge mclk);
        check({31'b0, irq}, 32'h0);
        apb(1, 12'h000, 32'h0);
        rd(12'h014, stateMask, 32'h0);
        check({31'b0, dmaReq}, 32'h0);
        report_and_stop();
    end
    // hang guard, far beyond the expected run length
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        report_and_stop();
    end
endmodule
